// ### dcc_defines.vh
// Purpose: Constants for the dual comparator control block
// Assumes: Avalon-MM slave with 32-bit data, word addressed by byte offset
// Notes: Notes on behaviour listed below
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define DCC_A_CTRL_OFS 4'h0
`define DCC_A_SEL_OFS 4'h4
`define DCC_A_MODE_OFS 4'h8
`define DCC_B_CTRL_OFS 4'hc
`define DCC_B_SEL_OFS 4'h0
`define DCC_B_MODE_OFS 4'h4
`define DCC_ST_OFS 4'h8
`define DCC_MASK_OFS 4'hc
`define DCC_BANK_A 1'b0
`define DCC_BANK_B 1'b1

// ==========================================================================
// Control register fields
`define DCC_EN_BIT 7
`define DCC_OUT_BIT 6
`define DCC_RISE_BIT 5
`define DCC_FALL_BIT 4
`define DCC_HYST_W 4
`define DCC_HYST_ZERO 4'h0

// ==========================================================================
// Select and mode register fields
`define DCC_SEL_MASK 8'h77
`define DCC_MODE_MASK 8'h33
`define DCC_MODE_RST 8'h02
`define DCC_RIE_BIT 5
`define DCC_FIE_BIT 4

// ==========================================================================
// Interrupt status layout: bit0 A rise, bit1 A fall, bit2 B rise, bit3 B fall
`define DCC_IRQ_W 4
`define DCC_IRQ_ZERO 4'h0
`define DCC_BYTE_ZERO 8'h00
`define DCC_PAD_W 24

`endif

// ### dcc_top.v
// Purpose: Control and status logic around two analog comparators
// Assumes: Comparator decisions arrive on cmp_*_decision; bus is Avalon-MM
// Notes: Register reads answer in one wait cycle; writes take effect at once
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "dcc_defines.vh"

module dcc_top (
    input wire clk,
    input wire rst,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire cmp_a_decision,
    input wire cmp_b_decision,
    output wire cmp_a_raw_out,
    output wire cmp_b_raw_out,
    output wire cmp_a_sync_out,
    output wire cmp_b_sync_out,
    output wire cmp_a_reset_src,
    output wire [3:0] cmp_a_pos_select,
    output wire [3:0] cmp_a_neg_select,
    output wire [3:0] cmp_b_pos_select,
    output wire [3:0] cmp_b_neg_select,
    output wire [1:0] response_mode_a,
    output wire [1:0] response_mode_b,
    output wire [1:0] cmp_enable_bits,
    output wire [3:0] hyst_a,
    output wire [3:0] hyst_b,
    output wire irq
);

    // ======================================================================
    // Storage
    reg [7:0] ctrl_q [0:1];
    reg [7:0] sel_q [0:1];
    reg [7:0] mode_q [0:1];
    reg [1:0] sync1_q;
    reg [1:0] sync2_q;
    reg [1:0] prev_q;
    reg [1:0] rise_ev;
    reg [1:0] fall_ev;
    reg [3:0] ist_q;
    reg [3:0] imask_q;
    reg rd_pend_q;
    reg [31:0] rdata_d;
    wire [1:0] decision;
    wire [1:0] en;
    wire wr_ok;
    wire rd_ok;
    wire bank;
    wire [3:0] ofs;
    wire [3:0] ev_vec;
    wire ist_rd;
    wire [1:0] ctrl_we;
    wire [1:0] sel_we;
    wire [1:0] mode_we;

    assign decision = {cmp_b_decision, cmp_a_decision};
    assign bank = avs_address[4];
    assign ofs = avs_address[3:0];
    assign wr_ok = avs_write & avs_byteenable[0];

    // Reads wait one cycle so data comes from a flip-flop; writes never wait
    assign avs_waitrequest = avs_read & ~rd_pend_q;
    assign rd_ok = avs_read & rd_pend_q;
    // Status clears on the capture edge so no event falls between capture and clear
    assign ist_rd = avs_read & ~rd_pend_q & (bank == `DCC_BANK_B) & (ofs == `DCC_ST_OFS);

    // Per-channel write strobes; channel B control lives in bank A
    assign ctrl_we[0] = wr_ok & (bank == `DCC_BANK_A) & (ofs == `DCC_A_CTRL_OFS);
    assign ctrl_we[1] = wr_ok & (bank == `DCC_BANK_A) & (ofs == `DCC_B_CTRL_OFS);
    assign sel_we[0] = wr_ok & (bank == `DCC_BANK_A) & (ofs == `DCC_A_SEL_OFS);
    assign sel_we[1] = wr_ok & (bank == `DCC_BANK_B) & (ofs == `DCC_B_SEL_OFS);
    assign mode_we[0] = wr_ok & (bank == `DCC_BANK_A) & (ofs == `DCC_A_MODE_OFS);
    assign mode_we[1] = wr_ok & (bank == `DCC_BANK_B) & (ofs == `DCC_B_MODE_OFS);

    // ======================================================================
    // Raw path: combinational only, gated low when disabled
    assign cmp_a_raw_out = decision[0] & en[0];
    assign cmp_b_raw_out = decision[1] & en[1];
    assign cmp_a_reset_src = cmp_a_raw_out;

    // ======================================================================
    // Per-channel synchroniser, edge detect and control register (identical channels)
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            assign en[gi] = ctrl_q[gi][`DCC_EN_BIT];
            // Two-stage synchroniser; only stage two is observed
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= decision[gi];
                    sync2_q[gi] <= sync1_q[gi] & en[gi];
                    prev_q[gi] <= sync2_q[gi];
                end
            end
            // Edge events from the synchronised result
            always @* begin
                rise_ev[gi] = sync2_q[gi] & ~prev_q[gi];
                fall_ev[gi] = ~sync2_q[gi] & prev_q[gi];
            end
            // Control, select and mode registers; edge sets beat software clear
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ctrl_q[gi] <= `DCC_BYTE_ZERO;
                    sel_q[gi] <= `DCC_BYTE_ZERO;
                    mode_q[gi] <= `DCC_MODE_RST;
                end else begin
                    if (ctrl_we[gi]) begin
                        ctrl_q[gi][`DCC_EN_BIT] <= avs_writedata[`DCC_EN_BIT];
                        ctrl_q[gi][`DCC_RISE_BIT] <= avs_writedata[`DCC_RISE_BIT];
                        ctrl_q[gi][`DCC_FALL_BIT] <= avs_writedata[`DCC_FALL_BIT];
                        ctrl_q[gi][`DCC_HYST_W-1:0] <= avs_writedata[`DCC_HYST_W-1:0];
                    end
                    if (rise_ev[gi])
                        ctrl_q[gi][`DCC_RISE_BIT] <= 1'b1;
                    if (fall_ev[gi])
                        ctrl_q[gi][`DCC_FALL_BIT] <= 1'b1;
                    if (sel_we[gi])
                        sel_q[gi] <= avs_writedata[7:0] & `DCC_SEL_MASK;
                    if (mode_we[gi])
                        mode_q[gi] <= avs_writedata[7:0] & `DCC_MODE_MASK;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Pin-facing outputs and configuration to the analog stage
    assign cmp_a_sync_out = sync2_q[0];
    assign cmp_b_sync_out = sync2_q[1];
    assign cmp_a_pos_select = {1'b0, sel_q[0][2:0]};
    assign cmp_a_neg_select = {1'b0, sel_q[0][6:4]};
    assign cmp_b_pos_select = {1'b0, sel_q[1][2:0]};
    assign cmp_b_neg_select = {1'b0, sel_q[1][6:4]};
    assign response_mode_a = mode_q[0][1:0];
    assign response_mode_b = mode_q[1][1:0];
    assign cmp_enable_bits = en;
    assign hyst_a = ctrl_q[0][`DCC_HYST_W-1:0];
    assign hyst_b = ctrl_q[1][`DCC_HYST_W-1:0];

    // ======================================================================
    // Interrupt status: edges gated by per-channel enables, sticky, cleared by read
    assign ev_vec = {fall_ev[1] & mode_q[1][`DCC_FIE_BIT],
                     rise_ev[1] & mode_q[1][`DCC_RIE_BIT],
                     fall_ev[0] & mode_q[0][`DCC_FIE_BIT],
                     rise_ev[0] & mode_q[0][`DCC_RIE_BIT]};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ist_q <= `DCC_IRQ_ZERO;
            imask_q <= `DCC_IRQ_ZERO;
        end else begin
            ist_q <= (ist_rd ? `DCC_IRQ_ZERO : ist_q) | ev_vec; // Set wins
            if (wr_ok && bank == `DCC_BANK_B && ofs == `DCC_MASK_OFS)
                imask_q <= avs_writedata[`DCC_IRQ_W-1:0];
        end
    end

    assign irq = |(ist_q & imask_q);

    // ======================================================================
    // Read mux; live result bit reads the synchronised state
    always @* begin
        rdata_d = 32'h00000000;
        if (bank == `DCC_BANK_A) begin
            case (ofs)
                `DCC_A_CTRL_OFS: rdata_d = {`DCC_PAD_W'h0, ctrl_q[0][7],
                    sync2_q[0], ctrl_q[0][5:0]};
                `DCC_A_SEL_OFS: rdata_d = {`DCC_PAD_W'h0, sel_q[0]};
                `DCC_A_MODE_OFS: rdata_d = {`DCC_PAD_W'h0, mode_q[0]};
                `DCC_B_CTRL_OFS: rdata_d = {`DCC_PAD_W'h0, ctrl_q[1][7],
                    sync2_q[1], ctrl_q[1][5:0]};
                default: rdata_d = 32'h00000000;
            endcase
        end else begin
            case (ofs)
                `DCC_B_SEL_OFS: rdata_d = {`DCC_PAD_W'h0, sel_q[1]};
                `DCC_B_MODE_OFS: rdata_d = {`DCC_PAD_W'h0, mode_q[1]};
                `DCC_ST_OFS: rdata_d = {28'h0000000, ist_q};
                `DCC_MASK_OFS: rdata_d = {28'h0000000, imask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // Read pipeline: capture data in the wait cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_pend_q <= avs_read & ~rd_pend_q;
            if (avs_read & ~rd_pend_q)
                avs_readdata <= rdata_d;
        end
    end

endmodule // dcc_top

// ### dcc_checker.sv
// Purpose: Port assertions for the dual comparator control block
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound onto dcc_top below
`timescale 1ns/1ps
module dcc_checker (
    input wire clk,
    input wire rst,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire cmp_a_decision,
    input wire cmp_a_raw_out,
    input wire cmp_a_sync_out,
    input wire cmp_a_reset_src,
    input wire [1:0] cmp_enable_bits,
    input wire [1:0] response_mode_a,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Channel A sequences
    sequence s_rise; cmp_enable_bits[0] && $rose(cmp_a_decision); endsequence
    sequence s_fall; cmp_enable_bits[0] && $fell(cmp_a_decision); endsequence
    sequence s_hi; (cmp_enable_bits[0] && cmp_a_decision) [*2]; endsequence
    sequence s_lo; (cmp_enable_bits[0] && !cmp_a_decision) [*2]; endsequence
    // ==========================================
    // Properties
    property p_raw; cmp_a_raw_out == (cmp_a_decision & cmp_enable_bits[0]); endproperty
    property p_rsrc; cmp_a_reset_src == cmp_a_raw_out; endproperty
    property p_sync_up; s_rise ##1 s_hi |-> cmp_a_sync_out; endproperty
    property p_sync_dn; s_fall ##1 s_lo |-> !cmp_a_sync_out; endproperty
    property p_off; !cmp_enable_bits[0] [*3] |-> !cmp_a_sync_out; endproperty
    property p_rd; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    property p_wr; avs_write |-> !avs_waitrequest; endproperty
    property p_init;
        $fell(rst) |-> response_mode_a == 2'h2 && cmp_enable_bits == 2'h0 && !irq;
    endproperty
    a_raw: assert property (p_raw) else $error("raw output mismatch");
    a_rsrc: assert property (p_rsrc) else $error("reset source mismatch");
    a_sync_up: assert property (p_sync_up) else $error("sync output late high");
    a_sync_dn: assert property (p_sync_dn) else $error("sync output late low");
    a_off: assert property (p_off) else $error("disabled output not low");
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    a_wr: assert property (p_wr) else $error("write stalled");
    a_init: assert property (p_init) else $error("reset values wrong");
endmodule // dcc_checker
bind dcc_top dcc_checker i_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .cmp_a_decision(cmp_a_decision), .cmp_a_raw_out(cmp_a_raw_out),
    .cmp_a_sync_out(cmp_a_sync_out), .cmp_a_reset_src(cmp_a_reset_src),
    .cmp_enable_bits(cmp_enable_bits), .response_mode_a(response_mode_a));

// ### tb_top.sv
// Purpose: Self-checking bench for dcc_top
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes: Bench drives bus and comparator decisions itself
`timescale 1ns/1ps
module tb_top;
    reg clk, rst, rw, ww, da, db;
    reg [4:0] ad;
    reg [31:0] wd, q;
    reg [3:0] be;
    wire [31:0] rdat;
    wire wq, ra, rb, sa, sb, rsa, irq;
    wire [3:0] pa, na, pb, nb, ha, hb;
    wire [1:0] ma, mb, en;
    integer errors = 0, n_tests = 0, i;
    dcc_top i_dut (.clk(clk), .rst(rst), .avs_address(ad), .avs_read(rw), .avs_write(ww),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
        .cmp_a_decision(da), .cmp_b_decision(db), .cmp_a_raw_out(ra), .cmp_b_raw_out(rb),
        .cmp_a_sync_out(sa), .cmp_b_sync_out(sb), .cmp_a_reset_src(rsa),
        .cmp_a_pos_select(pa), .cmp_a_neg_select(na), .cmp_b_pos_select(pb),
        .cmp_b_neg_select(nb), .response_mode_a(ma), .response_mode_b(mb),
        .cmp_enable_bits(en), .hyst_a(ha), .hyst_b(hb), .irq(irq));
    // ==========================================
    // Clock, compare and bus helpers
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task bus(input [4:0] a, input w, input [7:0] d, input [3:0] b);
        @(posedge clk);
        ad <= a;
        wd <= {24'h000000, d};
        be <= b;
        ww <= w;
        rw <= !w;
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        q = rdat;
        ww <= 1'b0;
        rw <= 1'b0;
    endtask
    task wr(input [4:0] a, input [7:0] d);
        bus(a, 1'b1, d, 4'h1);
        @(negedge clk);
    endtask
    task rd(input [4:0] a, input [7:0] e); bus(a, 1'b0, 8'h00, 4'hf); chk(q, {24'h0, e}); endtask
    // Change decisions, then wait past sync and flag latency
    task dec(input a, input b);
        @(posedge clk);
        da <= a;
        db <= b;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // ==========================================
    // Scenarios
    task t_reset;
        for (i = 0; i < 8; i = i + 1) rd(5'(i * 4), (i == 2 || i == 5) ? 8'h02 : 8'h00);
        rd(5'h01, 8'h00);
        chk({ma, mb, en}, 6'h28);
    endtask
    task t_cfg;
        wr(5'h04, 8'hff);
        rd(5'h04, 8'h77);
        wr(5'h10, 8'h35);
        chk({pa, na, pb, nb}, 16'h7753);
        for (i = 0; i < 4; i = i + 1) begin
            wr(5'h08, 8'h30 | 8'(i));
            chk(ma, i);
        end
        wr(5'h14, 8'h31);
        bus(5'h14, 1'b1, 8'h00, 4'he);
        rd(5'h14, 8'h31);
    endtask
    task t_edge;
        wr(5'h1c, 8'h0f);
        wr(5'h00, 8'h8e);
        chk({ha, en}, 6'h39);
        dec(1, 0);
        chk({ra, sa, rsa, irq}, 4'hf);
        rd(5'h00, 8'hee);
        rd(5'h18, 8'h01);
        @(negedge clk);
        chk(irq, 0);
        rd(5'h00, 8'hee);
        wr(5'h00, 8'h8e);
        rd(5'h00, 8'hce);
        dec(0, 0);
        rd(5'h00, 8'h9e);
        rd(5'h18, 8'h02);
        wr(5'h1c, 8'h00);
        dec(1, 0);
        chk(irq, 0);
        rd(5'h18, 8'h01);
        wr(5'h08, 8'h03);
        dec(0, 0);
        rd(5'h18, 8'h00);
        rd(5'h00, 8'hbe);
        dec(1, 0);
        wr(5'h00, 8'h00);
        @(negedge clk);
        chk(ra, 0);
        dec(1, 0);
        chk({ra, sa, rsa}, 3'h0);
    endtask
    task t_chan_b;
        wr(5'h0c, 8'h8b);
        chk(hb, 4'hb);
        wr(5'h0c, 8'h80);
        dec(0, 1);
        chk({rb, sb, en, rsa}, 5'h1c);
        rd(5'h0c, 8'he0);
        wr(5'h1c, 8'h04);
        @(negedge clk);
        chk(irq, 1);
        rd(5'h18, 8'h04);
    endtask
    // ==========================================
    // Verdict, watchdog and main sequence
    task results;
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        errors = errors + 1;
        results;
    end
    initial begin
        {rst, rw, ww, da, db, ad, wd, be} = {1'b1, 41'h0, 4'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_cfg;
        t_edge;
        t_chan_b;
        results;
    end
endmodule // tb_top
